// ---- adc_pkg.sv ----
package adc_pkg;
   // register map, byte offsets on the 8-bit address port
   localparam logic [7:0] ADC_STATUS_CTRL_OFS = 8'h00;
   localparam logic [7:0] ADC_RESULT_OFS = 8'h01;
   // converter_status_control field positions
   localparam int ADC_DONE_BIT = 7;
   localparam int ADC_RC_SEL_BIT = 6;
   localparam int ADC_POWER_BIT = 5;
   localparam int ADC_CHAN_LSB = 0;
   localparam int ADC_CHAN_W = 5;
   // values after reset
   localparam logic [ADC_CHAN_W-1:0] ADC_CHAN_RST = 5'h00;
   localparam logic [7:0] ADC_RESULT_RST = 8'h00;
   localparam logic [7:0] ADC_RDATA_NONE = 8'h00;
   // channel codes
   localparam logic [ADC_CHAN_W-1:0] ADC_CH_EXT_LAST = 5'h04;
   localparam logic [ADC_CHAN_W-1:0] ADC_CH_REF_HIGH = 5'h10;
   localparam logic [ADC_CHAN_W-1:0] ADC_CH_REF_MID = 5'h11;
   localparam logic [ADC_CHAN_W-1:0] ADC_CH_REF_LOW = 5'h12;
   localparam logic [ADC_CHAN_W-1:0] ADC_CH_FACTORY = 5'h13;
   localparam logic [7:0] ADC_RESERVED_RESULT = 8'h00;
   // conversion timing, in conversion clock periods
   localparam int ADC_CONV_PERIODS = 32;
   localparam logic [4:0] ADC_STEP_LOAD = 5'(ADC_CONV_PERIODS - 1);
   localparam logic [1:0] ADC_BIT_SPAN = 2'h3;
   localparam logic [7:0] ADC_FIRST_TRIAL = 8'h80;
   // conversion clock floor against the bus clock
   localparam int ADC_SYS_CLK_KHZ = 100000;
   localparam int ADC_CONV_MIN_KHZ = 1000;
   localparam int ADC_SYS_PER_CONV_MAX = ADC_SYS_CLK_KHZ / ADC_CONV_MIN_KHZ;
   localparam int ADC_SYS_PER_CONV = 1;
   typedef enum logic [1:0] {
      ADC_ST_OFF = 2'b00,
      ADC_ST_SAMPLE = 2'b01,
      ADC_ST_RESOLVE = 2'b11,
      ADC_ST_HOLD = 2'b10
   } adc_state_t;
   typedef struct packed {
      adc_state_t st;
      logic [4:0] step;
      logic [1:0] phase;
      logic [7:0] trial;
      logic [7:0] dac;
      logic [7:0] result;
      logic done;
      logic rc_sel;
      logic power_on;
      logic [ADC_CHAN_W-1:0] chan;
      logic run;
      logic sample;
      logic [7:0] rdata;
      logic [2:0] rc_sync;
      logic [1:0] comp_sync;
      logic [1:0] chip_sync;
   } adc_regs_t;
endpackage

// ---- adc_seq_ctrl.sv ----
// Function
// - one conversion takes 32 conversion clock periods, clock at least 1 MHz.
// - stop mode switches the RC oscillator off, power bit stays set.
// - wait mode does not disturb conversions or the done flag.
// - RC-paced results are moved into the result register on bus clock.
// - done flag is read-only, set when a conversion completes.
// - status write clears flag and restarts; result read clears flag.
// - conversions repeat every 32 periods until the status register is rewritten.
// - each new result overwrites the previous one regardless of the flag.
// - RC select bit clocks conversion from the RC oscillator.
// - power-on bit enables charge pump and current sources.
// - five-bit channel field picks pins 00-04 or references 10h-13h.
// - in single-chip mode channel 13h is reserved and converts to zero.
// - the 8-bit result loads at the moment the done flag sets.
// - stop mode turns off comparator and pump and aborts conversion.
// - stop mode leaves result and status/control contents untouched.
// - input sampled once at start, then compared against D/A output.
// - high reference gives ffh, low gives 00h, above saturates silently.
module adc_seq_ctrl
   import adc_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   // register port
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   // low-power and single-chip modes from the cpu
   input wire logic STOP_I,
   input wire logic SINGLE_CHIP_I,
   // analog side
   input wire logic RC_OSC_I,
   input wire logic COMP_I,
   output logic RC_OSC_EN_O,
   output logic PUMP_EN_O,
   output logic COMP_EN_O,
   output logic SAMPLE_O,
   output logic [ADC_CHAN_W-1:0] CHAN_O,
   output logic [7:0] DAC_O
);

   adc_regs_t r_r;
   adc_regs_t r_nxt;

   logic rc_rise;
   logic conv_tick;
   logic wr_ctrl;
   logic rd_result;
   logic done_set;
   logic done_clr;
   logic keep_bit;
   logic [7:0] dac_dec;

   // channel code that must read back as zero
   function automatic logic chan_reserved(input logic [ADC_CHAN_W-1:0] ch,
                                          input logic single_chip);
      chan_reserved = single_chip && (ch == ADC_CH_FACTORY);
   endfunction

   always_comb begin
      r_nxt = r_r;
      r_nxt.sample = 1'b0;
      r_nxt.rdata = ADC_RDATA_NONE;
      // pin synchronisers; only stage 1 and later are read
      r_nxt.rc_sync = {r_r.rc_sync[1:0], RC_OSC_I};
      r_nxt.comp_sync = {r_r.comp_sync[0], COMP_I};
      r_nxt.chip_sync = {r_r.chip_sync[0], SINGLE_CHIP_I};

      rc_rise = r_r.rc_sync[1] & ~r_r.rc_sync[2];
      // bus clock tick every cycle keeps well above the 1 MHz floor
      conv_tick = r_r.rc_sel ? rc_rise : 1'b1;
      wr_ctrl = WR_I && (ADDR_I == ADC_STATUS_CTRL_OFS);
      rd_result = RD_I && (ADDR_I == ADC_RESULT_OFS);
      done_set = 1'b0;
      keep_bit = r_r.comp_sync[1];
      dac_dec = keep_bit ? r_r.dac : (r_r.dac & ~r_r.trial);

      // register reads, data one cycle later
      if (RD_I) begin
         unique case (ADDR_I)
            ADC_STATUS_CTRL_OFS: begin
               r_nxt.rdata = {r_r.done, r_r.rc_sel, r_r.power_on, r_r.chan};
            end
            ADC_RESULT_OFS: begin
               r_nxt.rdata = r_r.result;
            end
            default: begin
               r_nxt.rdata = ADC_RDATA_NONE;
            end
         endcase
      end

      // done flag itself is not writable
      if (wr_ctrl) begin
         r_nxt.rc_sel = WDATA_I[ADC_RC_SEL_BIT];
         r_nxt.power_on = WDATA_I[ADC_POWER_BIT];
         r_nxt.chan = WDATA_I[ADC_CHAN_LSB +: ADC_CHAN_W];
         r_nxt.run = 1'b1;
      end

      // stop aborts; registers are left alone so it resumes afterwards
      if (STOP_I || !r_r.power_on || !r_r.run) begin
         r_nxt.st = ADC_ST_OFF;
         r_nxt.step = 5'h00;
         r_nxt.phase = 2'h0;
         r_nxt.trial = 8'h00;
         r_nxt.dac = 8'h00;
      end else if (wr_ctrl) begin
         r_nxt.st = ADC_ST_SAMPLE;
         r_nxt.step = 5'h00;
         r_nxt.phase = 2'h0;
         r_nxt.trial = 8'h00;
      end else if (conv_tick) begin
         unique case (r_r.st)
            ADC_ST_OFF: begin
               r_nxt.st = ADC_ST_SAMPLE;
               r_nxt.step = 5'h00;
            end
            ADC_ST_SAMPLE: begin
               // input held once, then only the d/a moves
               r_nxt.sample = 1'b1;
               r_nxt.step = r_r.step + 5'h01;
               r_nxt.phase = 2'h0;
               r_nxt.trial = ADC_FIRST_TRIAL;
               r_nxt.dac = ADC_FIRST_TRIAL;
               r_nxt.st = ADC_ST_RESOLVE;
            end
            ADC_ST_RESOLVE: begin
               r_nxt.step = r_r.step + 5'h01;
               // three periods per bit cover d/a settling plus comparator sync
               if (r_r.phase == ADC_BIT_SPAN - 2'h1) begin
                  r_nxt.phase = 2'h0;
                  r_nxt.trial = r_r.trial >> 1;
                  if (r_r.trial[0]) begin
                     r_nxt.dac = dac_dec;
                     r_nxt.st = ADC_ST_HOLD;
                  end else begin
                     r_nxt.dac = dac_dec | (r_r.trial >> 1);
                  end
               end else begin
                  r_nxt.phase = r_r.phase + 2'h1;
               end
            end
            ADC_ST_HOLD: begin
               if (r_r.step == ADC_STEP_LOAD) begin
                  r_nxt.step = 5'h00;
                  r_nxt.st = ADC_ST_SAMPLE;
                  if (chan_reserved(r_r.chan, r_r.chip_sync[1])) begin
                     r_nxt.result = ADC_RESERVED_RESULT;
                  end else begin
                     r_nxt.result = r_r.dac;
                  end
                  done_set = 1'b1;
               end else begin
                  r_nxt.step = r_r.step + 5'h01;
               end
            end
         endcase
      end

      // set beats a same-cycle clear; wait mode has no effect here
      done_clr = wr_ctrl || rd_result;
      r_nxt.done = done_set || (r_r.done && !done_clr);
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         r_r <= '{st: ADC_ST_OFF, step: 5'h00, phase: 2'h0, trial: 8'h00,
                  dac: 8'h00, result: ADC_RESULT_RST, done: 1'b0,
                  rc_sel: 1'b0, power_on: 1'b0, chan: ADC_CHAN_RST,
                  run: 1'b0, sample: 1'b0, rdata: ADC_RDATA_NONE,
                  rc_sync: 3'h0, comp_sync: 2'h0, chip_sync: 2'h0};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign RDATA_O = r_r.rdata;
   // analog enables drop in stop without touching the stored bits
   assign RC_OSC_EN_O = r_r.rc_sel & ~STOP_I;
   assign PUMP_EN_O = r_r.power_on & ~STOP_I;
   assign COMP_EN_O = r_r.power_on & ~STOP_I;
   assign SAMPLE_O = r_r.sample;
   assign CHAN_O = r_r.chan;
   assign DAC_O = r_r.dac;

endmodule // adc_seq_ctrl

// ---- adc_seq_ctrl_chk.sv ----
module adc_seq_ctrl_chk
   import adc_pkg::*;
(
   // clock, reset, register port
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   // mode and analog side
   input wire logic STOP_I,
   input wire logic RC_OSC_EN_O,
   input wire logic PUMP_EN_O,
   input wire logic COMP_EN_O,
   input wire logic SAMPLE_O,
   input wire logic [4:0] CHAN_O,
   input wire logic [7:0] DAC_O
);
   default clocking @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!ARST_N_I);
   logic [5:0] gap_r;
   logic clean_r;
   // period only judged on undisturbed bus-clock runs
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         gap_r <= 6'h00;
         clean_r <= 1'b0;
      end else begin
         gap_r <= SAMPLE_O ? 6'h00 : gap_r + 6'h01;
         clean_r <= (SAMPLE_O | clean_r) & ~WR_I & ~STOP_I & ~RC_OSC_EN_O & PUMP_EN_O;
      end
   end
   AST_STOP_OFF: assert property (STOP_I |-> !PUMP_EN_O && !COMP_EN_O && !RC_OSC_EN_O)
      else $error("enable high in stop");
   AST_COMP_PUMP: assert property (COMP_EN_O == PUMP_EN_O)
      else $error("comparator and pump enables differ");
   AST_PERIOD: assert property (SAMPLE_O && clean_r |-> gap_r == 6'd31)
      else $error("conversion period wrong");
   AST_NO_LATE: assert property (clean_r |-> gap_r < 6'd32)
      else $error("conversion did not repeat");
   AST_PULSE: assert property (SAMPLE_O |=> !SAMPLE_O)
      else $error("sample pulse too long");
   AST_FIRST: assert property (SAMPLE_O |-> DAC_O == ADC_FIRST_TRIAL)
      else $error("first trial not msb");
   AST_STOP_DAC: assert property (STOP_I[*3] |-> DAC_O == 8'h00 && !SAMPLE_O)
      else $error("converter active in stop");
   AST_OFF_QUIET: assert property (!PUMP_EN_O[*3] |-> !SAMPLE_O)
      else $error("sampling while powered off");
   AST_CHAN: assert property (WR_I && ADDR_I == ADC_STATUS_CTRL_OFS ##1 !WR_I[*2]
      |-> {3'h0, CHAN_O} == ($past(WDATA_I, 2) & 8'h1f))
      else $error("channel select not applied");
   COV_RUN: cover property (SAMPLE_O && clean_r);
   COV_STOP: cover property (STOP_I && $past(PUMP_EN_O));
   COV_RC: cover property (RC_OSC_EN_O ##1 !RC_OSC_EN_O);
endmodule // adc_seq_ctrl_chk
bind adc_seq_ctrl adc_seq_ctrl_chk u_adc_seq_ctrl_chk (.CLK_SYS_I, .ARST_N_I, .ADDR_I, .WDATA_I,
   .WR_I, .STOP_I, .RC_OSC_EN_O, .PUMP_EN_O, .COMP_EN_O, .SAMPLE_O, .CHAN_O, .DAC_O);

// ---- adc_analog_model.sv ----
module adc_analog_model (
   input wire logic clk_i,
   input wire logic [255:0] lvl_i,
   input wire logic [4:0] chan_i,
   input wire logic [7:0] dac_i,
   input wire logic sample_i,
   input wire logic comp_en_i,
   input wire logic rc_en_i,
   output logic comp_o,
   output logic rc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] held = 8'h00;
   logic junk = 1'b0;
   always @(posedge clk_i) begin
      junk <= ~junk;
      if (sample_i) held <= lvl_i[chan_i*8 +: 8];
   end
   // a disabled comparator floats, so show a moving level
   assign comp_o = comp_en_i ? ((sample_i ? lvl_i[chan_i*8 +: 8] : held) >= dac_i) : junk;
   initial begin
      rc_o = 1'b0;
      forever begin
         #333;
         if (rc_en_i) rc_o = ~rc_o;
      end
   end
endmodule // adc_analog_model

// ---- test_adc_seq_ctrl.sv ----
module test_adc_seq_ctrl;
   import adc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, wr, rd, stop, chip, rc, comp, rc_en, pump, cen, smp;
   logic [7:0] addr, wdata, rdata, dac, d;
   logic [4:0] chan;
   logic [255:0] lvl;
   int vin[32];
   int chs[10] = '{0, 1, 2, 3, 4, 16, 17, 18, 19, 9};
   int err_total, n_compared, ch, old;
   adc_seq_ctrl u_adc_seq_ctrl (.CLK_SYS_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STOP_I(stop), .SINGLE_CHIP_I(chip), .RC_OSC_I(rc),
      .COMP_I(comp), .RC_OSC_EN_O(rc_en), .PUMP_EN_O(pump), .COMP_EN_O(cen), .SAMPLE_O(smp),
      .CHAN_O(chan), .DAC_O(dac));
   adc_analog_model u_adc_analog_model (.clk_i(clk), .lvl_i(lvl), .chan_i(chan), .dac_i(dac),
      .sample_i(smp), .comp_en_i(cen), .rc_en_i(rc_en), .comp_o(comp), .rc_o(rc));
   function automatic int exp_res(int c);
      return (c == 19 && chip) ? 0 : vin[c];
   endfunction
   task automatic bus_wr(input logic [7:0] a, v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // read data stand for this one cycle only; take them mid-cycle, settled
      @(negedge clk);
      v = rdata;
      @(posedge clk);
   endtask
   task automatic cmp(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk(input logic [7:0] a, exp);
      logic [7:0] v;
      bus_rd(a, v);
      cmp(v, exp);
   endtask
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial begin
      {rst_n, wr, rd, stop, chip, addr, wdata, lvl} = '0;
      void'($urandom(32'hecea98ee));
      foreach (vin[i]) vin[i] = $urandom_range(255);
      vin[16] = 255;
      vin[17] = 128;
      vin[18] = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      chk(ADC_STATUS_CTRL_OFS, 8'h00);
      bus_wr(ADC_RESULT_OFS, 8'hff);
      chk(ADC_RESULT_OFS, 8'h00);
      chk(8'h05, 8'h00);
      foreach (chs[i]) begin
         ch = chs[i];
         chip <= 1'($urandom_range(1));
         foreach (vin[j]) lvl[j*8 +: 8] <= 8'(vin[j]);
         repeat (4) @(posedge clk);
         old = exp_res(ch);
         bus_wr(ADC_STATUS_CTRL_OFS, 8'ha0 | 8'(ch));
         chk(ADC_STATUS_CTRL_OFS, 8'h20 | 8'(ch));
         repeat (18) @(posedge clk);
         if (ch < 16 || ch > 19) vin[ch] = $urandom_range(255);
         foreach (vin[j]) lvl[j*8 +: 8] <= 8'(vin[j]);
         repeat (20) @(posedge clk);
         chk(ADC_STATUS_CTRL_OFS, 8'ha0 | 8'(ch));
         chk(ADC_RESULT_OFS, 8'(old));
         chk(ADC_STATUS_CTRL_OFS, 8'h20 | 8'(ch));
         repeat (32) @(posedge clk);
         chk(ADC_RESULT_OFS, 8'(exp_res(ch)));
      end
      old = exp_res(ch);
      bus_wr(ADC_STATUS_CTRL_OFS, 8'h22);
      repeat (10) @(posedge clk);
      stop <= 1'b1;
      repeat (50) @(posedge clk);
      chk(ADC_STATUS_CTRL_OFS, 8'h22);
      chk(ADC_RESULT_OFS, 8'(old));
      stop <= 1'b0;
      repeat (40) @(posedge clk);
      chk(ADC_STATUS_CTRL_OFS, 8'ha2);
      bus_wr(ADC_STATUS_CTRL_OFS, 8'h70);
      d = 8'h00;
      for (int k = 0; k < 3000 && d[7] !== 1'b1; k++) bus_rd(ADC_STATUS_CTRL_OFS, d);
      cmp(d, 8'hf0);
      chk(ADC_RESULT_OFS, 8'hff);
      stop <= 1'b1;
      @(negedge clk);
      cmp({5'h00, cen, pump, rc_en}, 8'h00);
      @(posedge clk);
      chk(ADC_STATUS_CTRL_OFS, 8'h70);
      stop <= 1'b0;
      // idle converter left fully powered down
      bus_wr(ADC_STATUS_CTRL_OFS, 8'h00);
      chk(ADC_STATUS_CTRL_OFS, 8'h00);
      @(negedge clk);
      cmp({5'h00, cen, pump, rc_en}, 8'h00);
      wrap_up();
   end
endmodule // test_adc_seq_ctrl
